// ===== design/irq_params.svh
// Functional notes
// R1: global enable passes all unmasked requests
// R2: any reset clears global enable
// R3: service clears enable, pushes, vectors 0004h
// R4: flags set regardless of any enable
// R5: events during service only set flags
// R6: enable cleared just before sample blocks take
// R7: return pops, restores context, sets enable
// R8: pin-to-vector latency three or four cycles
// R9: external pin edge chosen by select bit
// R10: valid edge sets external pin flag
// R11: external pin wakes Sleep if pre-enabled
// R12: analog pins read zero, never interrupt
// R13: peripheral group enable gates peripheral sources
// R14: timer0 rollover flag, software clears only
// R15: pin-change flag needs per-pin select
// R16: software clears external flag before re-enabling
// R17: flags hold until software writes zero
// R18: external flag sampled every Q1 phase
// R19: first peripheral enable register bit layout
// R20: accepts all listed core and peripheral sources
// R21: request is enable-gated OR of flags
`ifndef IRQ_PARAMS_SVH
`define IRQ_PARAMS_SVH

// apb register byte offsets
`define IRQ_ADDR_CONTROL    8'h00
`define IRQ_ADDR_PEN_ONE    8'h04
`define IRQ_ADDR_CONFIG     8'h08
`define IRQ_ADDR_PFLAGS     8'h0C
`define IRQ_ADDR_PEN_TWO    8'h10
`define IRQ_ADDR_STATE      8'h14

// interrupt_control bit positions
`define IRQ_GIE_BIT         7
`define IRQ_PERIPHERAL_GROUP_ENABLE_BIT        6
`define IRQ_TIMER0_OVERFLOW_ENABLE_BIT        5
`define IRQ_EXT_PIN_IRQ_ENABLE_BIT        4
`define IRQ_PIN_CHANGE_ENABLE_BIT        3
`define IRQ_TIMER0_OVERFLOW_FLAG_BIT        2
`define IRQ_EXT_PIN_IRQ_FLAG_BIT        1
`define IRQ_PIN_CHANGE_FLAG_BIT        0

// implemented bits of the peripheral enable / flag bytes
`define IRQ_PEN_ONE_MASK    8'h73
`define IRQ_PEN_TWO_MASK    8'hB2

// config register fields
`define IRQ_CFG_EDGE_BIT    0
`define IRQ_CFG_CHG_LSB     8
`define IRQ_CFG_ANA_LSB     16

// reset values
`define IRQ_CONTROL_RST     8'h00
`define IRQ_BYTE_RST        8'h00
`define IRQ_PC_RST          13'h0000

// sequencing constants
`define IRQ_VECTOR_PC       13'h0004
`define IRQ_Q1_PHASE        2'd0
`define IRQ_EXT_PIN_IDX     2
`define IRQ_PIN_COUNT       8

`endif

// ===== design/irq_pkg.sv
package irq_pkg;

  // one-hot service sequencer states
  typedef enum logic [2:0] {
    ST_RUN    = 3'b001,  // normal execution, sampling at Q1
    ST_DUMMY1 = 3'b010,  // first forced dummy cycle
    ST_DUMMY2 = 3'b100   // second dummy cycle, vector at next Q1
  } seq_state_e;

  // synchroniser state, three stages and the agreed level
  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] level;
  } sync_s;

  // whole state of the interrupt logic
  typedef struct packed {
    logic [1:0]  qphase;
    seq_state_e  seq;
    logic [7:0]  control;
    logic [7:0]  pen_one;
    logic [7:0]  pen_two;
    logic [7:0]  pflag_one;
    logic [7:0]  pflag_two;
    logic        edge_sel;
    logic [7:0]  change_sel;
    logic [7:0]  analog_sel;
    logic        ext_prev;
    logic [7:0]  chg_prev;
    logic        sleep_prev;
    logic        sleep_ext_pin_irq_enable;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        vector;
    logic [12:0] pc;
    logic        push;
    logic [12:0] push_addr;
    logic        pop;
    logic        restore;
    logic        wake;
    logic [7:0]  pin_level;
  } ctl_s;

endpackage : irq_pkg

// ===== design/irq_pin_sync.sv
`timescale 1ns/1ps
module irq_pin_sync
  import irq_pkg::*;
(
  // clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rstn,
  // raw pins
  input  wire logic [7:0] i_pins,
  // filtered pin levels
  output logic      [7:0] o_level
);

  sync_s st;       // registered state
  sync_s next_st;  // next state

  ////////////////////////////////////////////////////////////////////////////
  // three stages; a level is accepted only once stages two and three agree
  always_comb begin
    next_st    = st;
    next_st.s1 = i_pins;
    next_st.s2 = st.s1;  // stage one feeds stage two only
    next_st.s3 = st.s2;
    for (int i = 0; i < 8; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.level[i] = st.s3[i];
      end
    end
  end

  // registers; reset level is low so a pin low at reset shows no edge afterwards
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_level = st.level;

endmodule : irq_pin_sync

// ===== design/mcu_interrupt_logic.sv
`timescale 1ns/1ps
`include "irq_params.svh"
module mcu_interrupt_logic
  import irq_pkg::*;
(
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rstn,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // asynchronous general purpose pins
  input  wire logic [7:0]  i_gpio,
  output logic      [7:0]  o_pin_level,
  // core event pulses, same clock
  input  wire logic        i_timer0_rollover,
  input  wire logic        i_timer1_overflow,
  input  wire logic        i_timer2_match,
  input  wire logic        i_adc_done,
  input  wire logic        i_serial_event,
  input  wire logic        i_bus_collision,
  // power stage monitor pulses, same clock
  input  wire logic        i_out_overvoltage,
  input  wire logic        i_out_undervoltage,
  input  wire logic        i_out_overcurrent,
  input  wire logic        i_in_undervoltage,
  // core sequencer side
  input  wire logic        i_sleep,
  input  wire logic        i_gie_clear_exec,
  input  wire logic        i_return_from_irq,
  input  wire logic [12:0] i_return_addr,
  output logic             o_irq_vector,
  output logic      [12:0] o_vector_pc,
  output logic             o_push_ret,
  output logic      [12:0] o_push_addr,
  output logic             o_pop_ret,
  output logic             o_restore_context,
  output logic             o_wake
);

  ctl_s        st;          // registered state
  ctl_s        next_st;     // next state
  logic [7:0]  sync_level;  // filtered pin levels
  logic [7:0]  masked;      // pin levels with analog pins forced low
  logic        q1;          // first phase of an instruction cycle
  logic        ext_hit;     // valid edge on the external interrupt pin
  logic        chg_hit;     // a selected pin changed
  logic        core_req;    // enabled flags held in interrupt_control
  logic        periph_req;  // enabled peripheral flags behind the group enable
  logic        take;        // service starts this cycle
  logic        wr_commit;   // write completes at this edge
  logic        rd_access;   // first cycle of an access phase
  logic [31:0] rd_word;     // read mux result
  logic        rd_hit;      // address decodes to a register
  logic [7:0]  wr_byte;     // low byte of write data
  logic [7:0]  ev_one;      // peripheral events, first flag byte
  logic [7:0]  ev_two;      // monitor events, second flag byte

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser, three flip-flops and agreement filter per pin
  irq_pin_sync u_pin_sync (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .i_pins    (i_gpio),
    .o_level   (sync_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pin conditioning and edge / change detection
  always_comb begin
    // analog pins read as zero and can never produce an edge
    masked  = sync_level & ~st.analog_sel;  // [R12]
    // rising edge when the select is one, falling when zero
    if (st.edge_sel) begin
      ext_hit = masked[`IRQ_EXT_PIN_IDX] & ~st.ext_prev;  // [R9]
    end else begin
      ext_hit = ~masked[`IRQ_EXT_PIN_IDX] & st.ext_prev;  // [R9]
    end
    // any selected digital pin that differs from its last seen level
    chg_hit = |((masked ^ st.chg_prev) & st.change_sel);  // [R15]
  end

  ////////////////////////////////////////////////////////////////////////////
  // event bytes laid out like the flag registers they land in
  always_comb begin
    ev_one = {1'b0, i_adc_done, i_bus_collision, i_serial_event,
              2'b00, i_timer2_match, i_timer1_overflow};  // [R20]
    ev_two = {i_out_undervoltage, 1'b0, i_out_overcurrent, i_out_overvoltage,
              2'b00, i_in_undervoltage, 1'b0};  // [R20]
  end

  ////////////////////////////////////////////////////////////////////////////
  // request logic, always from registered flags so a request seen at q1
  // matches what software would read back in the same cycle
  always_comb begin
    core_req   = (st.control[`IRQ_TIMER0_OVERFLOW_ENABLE_BIT] & st.control[`IRQ_TIMER0_OVERFLOW_FLAG_BIT])   // [R14]
               | (st.control[`IRQ_EXT_PIN_IRQ_ENABLE_BIT] & st.control[`IRQ_EXT_PIN_IRQ_FLAG_BIT])   // [R16]
               | (st.control[`IRQ_PIN_CHANGE_ENABLE_BIT] & st.control[`IRQ_PIN_CHANGE_FLAG_BIT]); // [R15]
    // peripheral sources only count behind the group enable
    periph_req = st.control[`IRQ_PERIPHERAL_GROUP_ENABLE_BIT]
               & (|(st.pflag_one & st.pen_one) | |(st.pflag_two & st.pen_two));  // [R13]
    q1         = (st.qphase == `IRQ_Q1_PHASE);  // [R18]
    // sampled once per instruction cycle, only with global enable set;
    // an enable-clearing instruction in the same cycle wins, and the
    // flag is left alone so the request is still pending later
    take       = q1 & (st.seq == ST_RUN) & ~i_sleep
               & st.control[`IRQ_GIE_BIT] & ~i_gie_clear_exec  // [R1] [R6]
               & (core_req | periph_req);  // [R21]
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb decode and read mux
  always_comb begin
    wr_byte   = i_pwdata[7:0];
    rd_access = i_psel & i_penable & ~st.pready;
    wr_commit = i_psel & i_penable & st.pready & i_pwrite;
    rd_hit    = 1'b1;
    rd_word   = 32'h0000_0000;
    unique case (i_paddr)
      `IRQ_ADDR_CONTROL: rd_word[7:0] = st.control;
      `IRQ_ADDR_PEN_ONE: rd_word[7:0] = st.pen_one;  // [R19]
      `IRQ_ADDR_CONFIG: begin
        rd_word[`IRQ_CFG_EDGE_BIT]            = st.edge_sel;
        rd_word[`IRQ_CFG_CHG_LSB +: 8]        = st.change_sel;
        rd_word[`IRQ_CFG_ANA_LSB +: 8]        = st.analog_sel;
      end
      `IRQ_ADDR_PFLAGS: begin
        rd_word[7:0]  = st.pflag_one;
        rd_word[15:8] = st.pflag_two;
      end
      `IRQ_ADDR_PEN_TWO: rd_word[7:0] = st.pen_two;
      `IRQ_ADDR_STATE: begin
        // live view of the sequencer, sleep latch and conditioned pins
        rd_word[2:0]   = st.seq;
        rd_word[3]     = st.wake;
        rd_word[4]     = st.sleep_ext_pin_irq_enable;
        rd_word[7:6]   = st.qphase;
        rd_word[15:8]  = st.pin_level;  // [R12]
      end
      default: rd_hit = 1'b0;  // unmapped: zero data and an error
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_st = st;
    // one-cycle strobes toward the core drop by default
    next_st.vector  = 1'b0;
    next_st.push    = 1'b0;
    next_st.pop     = 1'b0;
    next_st.restore = 1'b0;

    // free running q-phase counter, four reference clocks per cycle
    next_st.qphase = st.qphase + 2'd1;

    // remember conditioned pin levels for the next comparison
    next_st.ext_prev  = masked[`IRQ_EXT_PIN_IDX];
    next_st.chg_prev  = masked;
    next_st.pin_level = masked;  // [R12]

    // apb handshake: answer one cycle into the access phase
    if (rd_access) begin
      next_st.pready  = 1'b1;
      next_st.pslverr = ~rd_hit;
      next_st.prdata  = i_pwrite ? 32'h0000_0000 : rd_word;
    end else begin
      next_st.pready  = 1'b0;
      next_st.pslverr = 1'b0;
    end

    // software writes take effect at the edge that completes the access;
    // flags are writable both ways, unimplemented bits stay zero
    if (wr_commit) begin
      unique case (i_paddr)
        `IRQ_ADDR_CONTROL: next_st.control   = wr_byte;  // [R17]
        `IRQ_ADDR_PEN_ONE: next_st.pen_one   = wr_byte & `IRQ_PEN_ONE_MASK;  // [R19]
        `IRQ_ADDR_CONFIG: begin
          next_st.edge_sel   = i_pwdata[`IRQ_CFG_EDGE_BIT];  // [R9]
          next_st.change_sel = i_pwdata[`IRQ_CFG_CHG_LSB +: 8];
          next_st.analog_sel = i_pwdata[`IRQ_CFG_ANA_LSB +: 8];
        end
        `IRQ_ADDR_PFLAGS: begin
          next_st.pflag_one = wr_byte & `IRQ_PEN_ONE_MASK;  // [R17]
          next_st.pflag_two = i_pwdata[15:8] & `IRQ_PEN_TWO_MASK;
        end
        `IRQ_ADDR_PEN_TWO: next_st.pen_two = wr_byte & `IRQ_PEN_TWO_MASK;
        default: ;  // read-only or unmapped, nothing stored
      endcase
    end

    // hardware sets after the software write so a set in the same cycle
    // as a clear survives; no enable of any kind gates the flags
    if (i_timer0_rollover) begin
      next_st.control[`IRQ_TIMER0_OVERFLOW_FLAG_BIT] = 1'b1;  // [R14] [R4]
    end
    if (ext_hit) begin
      next_st.control[`IRQ_EXT_PIN_IRQ_FLAG_BIT] = 1'b1;  // [R10] [R4]
    end
    if (chg_hit) begin
      next_st.control[`IRQ_PIN_CHANGE_FLAG_BIT] = 1'b1;  // [R15] [R4]
    end
    next_st.pflag_one = next_st.pflag_one | ev_one;  // [R4] [R5]
    next_st.pflag_two = next_st.pflag_two | ev_two;  // [R4] [R5]

    // instruction clearing the global enable, executed by the core
    if (i_gie_clear_exec) begin
      next_st.control[`IRQ_GIE_BIT] = 1'b0;  // [R6]
    end

    // return: pop address, restore shadow context, reopen the gate
    if (i_return_from_irq) begin
      next_st.pop                    = 1'b1;  // [R7]
      next_st.restore                = 1'b1;  // [R7]
      next_st.control[`IRQ_GIE_BIT]  = 1'b1;  // [R7]
    end

    // service sequencer: sample at q1, two dummy cycles, vector at q1
    unique case (st.seq)
      ST_RUN: begin
        if (take) begin
          next_st.control[`IRQ_GIE_BIT] = 1'b0;           // [R3] [R5]
          next_st.push                  = 1'b1;           // [R3]
          next_st.push_addr             = i_return_addr;  // [R3]
          next_st.seq                   = ST_DUMMY1;      // [R8]
        end
      end
      ST_DUMMY1: begin
        if (q1) begin
          next_st.seq = ST_DUMMY2;  // [R8]
        end
      end
      ST_DUMMY2: begin
        if (q1) begin
          next_st.vector = 1'b1;             // [R3] [R8]
          next_st.pc     = `IRQ_VECTOR_PC;   // [R3]
          next_st.seq    = ST_RUN;
        end
      end
      default: next_st.seq = ST_RUN;  // illegal one-hot code recovers
    endcase

    // sleep entry captures the external pin enable; only an enable set
    // beforehand may wake the core through the external pin
    next_st.sleep_prev = i_sleep;
    if (i_sleep & ~st.sleep_prev) begin
      next_st.sleep_ext_pin_irq_enable = st.control[`IRQ_EXT_PIN_IRQ_ENABLE_BIT];  // [R11]
    end
    // wake is held while the core sleeps and drops once it runs;
    // it ignores the global enable, vectoring then follows if it is set
    if (i_sleep) begin
      next_st.wake = st.wake
                   | (st.sleep_ext_pin_irq_enable & st.control[`IRQ_EXT_PIN_IRQ_FLAG_BIT])  // [R11]
                   | (st.control[`IRQ_TIMER0_OVERFLOW_ENABLE_BIT] & st.control[`IRQ_TIMER0_OVERFLOW_FLAG_BIT])
                   | (st.control[`IRQ_PIN_CHANGE_ENABLE_BIT] & st.control[`IRQ_PIN_CHANGE_FLAG_BIT])
                   | periph_req;
    end else begin
      next_st.wake = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; reset clears every enable, the global one included
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st            <= '0;
      st.seq        <= ST_RUN;
      st.control    <= `IRQ_CONTROL_RST;  // [R2]
      st.pen_one    <= `IRQ_BYTE_RST;
      st.pen_two    <= `IRQ_BYTE_RST;
      st.pflag_one  <= `IRQ_BYTE_RST;
      st.pflag_two  <= `IRQ_BYTE_RST;
      st.pc         <= `IRQ_PC_RST;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign o_prdata          = st.prdata;
  assign o_pready          = st.pready;
  assign o_pslverr         = st.pslverr;
  assign o_pin_level       = st.pin_level;
  assign o_irq_vector      = st.vector;
  assign o_vector_pc       = st.pc;
  assign o_push_ret        = st.push;
  assign o_push_addr       = st.push_addr;
  assign o_pop_ret         = st.pop;
  assign o_restore_context = st.restore;
  assign o_wake            = st.wake;

endmodule : mcu_interrupt_logic

// ===== testbench/irq_chk.sv
`timescale 1ns/1ps
module irq_chk (
  input wire logic        i_ref_clk,
  input wire logic        i_rstn,
  input wire logic        i_sleep,
  input wire logic        i_gie_clear_exec,
  input wire logic        i_return_from_irq,
  input wire logic [12:0] i_return_addr,
  input wire logic        o_irq_vector,
  input wire logic [12:0] o_vector_pc,
  input wire logic        o_push_ret,
  input wire logic [12:0] o_push_addr,
  input wire logic        o_pop_ret,
  input wire logic        o_restore_context,
  input wire logic        o_wake
);
  // everything here lives in the one core clock domain
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  ////////////////////////////////////////////////////////////////////////////
  push_to_vector_a: assert property (
    o_push_ret |-> ##8 (o_irq_vector && o_vector_pc == 13'h0004))
    else $error("vector did not follow push by eight cycles");
  vector_cause_a: assert property (
    o_irq_vector |-> $past(o_push_ret, 8)) else $error("vector without push");
  push_addr_a: assert property (
    o_push_ret |-> o_push_addr == $past(i_return_addr)) else $error("wrong push address");
  single_service_a: assert property (
    o_push_ret |=> !o_push_ret [*8]) else $error("second service inside dummy cycles");
  clear_blocks_a: assert property (
    i_gie_clear_exec |=> !o_push_ret) else $error("take while enable being cleared");
  sleep_blocks_a: assert property (
    i_sleep |=> !o_push_ret) else $error("take while asleep");
  return_pops_a: assert property (
    i_return_from_irq |=> (o_pop_ret && o_restore_context)) else $error("return not popped");
  pop_cause_a: assert property (
    o_pop_ret |-> $past(i_return_from_irq)) else $error("pop without return");
  wake_cause_a: assert property (
    o_wake |-> $past(i_sleep)) else $error("wake outside sleep");
endmodule : irq_chk

bind mcu_interrupt_logic irq_chk u_chk (
  .i_ref_clk, .i_rstn, .i_sleep, .i_gie_clear_exec, .i_return_from_irq, .i_return_addr,
  .o_irq_vector, .o_vector_pc, .o_push_ret, .o_push_addr, .o_pop_ret, .o_restore_context,
  .o_wake
);

// ===== testbench/core_model.sv
`timescale 1ns/1ps
module core_model (
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rstn,
  // service strobes from the interrupt logic
  input  wire logic        i_vector,
  input  wire logic [12:0] i_vector_pc,
  input  wire logic        i_push,
  input  wire logic [12:0] i_push_addr,
  input  wire logic        i_pop,
  // program counter and stack depth seen by the bench
  output logic      [12:0] o_pc,
  output logic      [3:0]  o_depth
);
  logic [12:0] stack [8];  // eight deep, overflow wraps like the real stack
  ////////////////////////////////////////////////////////////////////////////
  // simple sequencer: pc steps each cycle unless redirected
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pc    <= 13'h0000;
      o_depth <= 4'h0;
    end else begin
      if (i_push) begin
        stack[o_depth[2:0]] <= i_push_addr;
        o_depth             <= o_depth + 4'h1;
      end
      if (i_vector) begin
        o_pc <= i_vector_pc;
      end else if (i_pop) begin
        o_pc    <= stack[o_depth[2:0] - 3'h1];
        o_depth <= o_depth - 4'h1;
      end else begin
        o_pc <= o_pc + 13'h0001;
      end
    end
  end
endmodule : core_model

// ===== testbench/test_mcu_interrupt_logic.sv
`timescale 1ns/1ps
module test_mcu_interrupt_logic;
  logic i_ref_clk, i_rstn, i_psel, i_penable, i_pwrite, i_sleep, i_gie_clear_exec;
  logic i_return_from_irq, o_pready, o_pslverr, o_irq_vector, o_push_ret, o_pop_ret;
  logic o_restore_context, o_wake, i_timer0_rollover, i_timer1_overflow, i_timer2_match;
  logic i_adc_done, i_serial_event, i_bus_collision, i_out_overvoltage, i_out_undervoltage;
  logic i_out_overcurrent, i_in_undervoltage;
  logic [7:0]  i_paddr, i_gpio, o_pin_level;
  logic [31:0] i_pwdata, o_prdata;
  logic [12:0] i_return_addr, o_vector_pc, o_push_addr;
  logic [9:0]  ev;      // one-hot event pulses, index 0 is timer0
  logic [3:0]  depth;   // stack depth held by the core model
  int errors, num_checks, cycles, n;
  logic [31:0] x;
  logic        pe;      // error flag of a direct transfer
  int fb [1:9] = '{0, 1, 4, 5, 6, 9, 12, 13, 15};  // flag bit of each peripheral event
  logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
  assign {i_out_undervoltage, i_out_overcurrent, i_out_overvoltage, i_in_undervoltage,
          i_adc_done, i_bus_collision, i_serial_event, i_timer2_match, i_timer1_overflow,
          i_timer0_rollover} = ev;
  mcu_interrupt_logic uut (.i_ref_clk, .i_rstn, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_gpio, .o_pin_level, .i_timer0_rollover,
    .i_timer1_overflow, .i_timer2_match, .i_adc_done, .i_serial_event, .i_bus_collision,
    .i_out_overvoltage, .i_out_undervoltage, .i_out_overcurrent, .i_in_undervoltage,
    .i_sleep, .i_gie_clear_exec, .i_return_from_irq, .i_return_addr, .o_irq_vector,
    .o_vector_pc, .o_push_ret, .o_push_addr, .o_pop_ret, .o_restore_context, .o_wake);
  core_model u_core (.i_ref_clk, .i_rstn, .i_vector(o_irq_vector), .i_vector_pc(o_vector_pc),
    .i_push(o_push_ret), .i_push_addr(o_push_addr), .i_pop(o_pop_ret),
    .o_pc(i_return_addr), .o_depth(depth));
  ////////////////////////////////////////////////////////////////////////////
  always #4 i_ref_clk = ~i_ref_clk;
  // hang guard: whole run is a few hundred cycles
  always @(posedge i_ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // one apb transfer; held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge i_ref_clk);
    i_psel <= 1'b1; i_penable <= 1'b0; i_pwrite <= w; i_paddr <= a; i_pwdata <= d;
    @(posedge i_ref_clk);
    i_penable <= 1'b1;
    do @(posedge i_ref_clk); while (o_pready !== 1'b1);
    r = o_prdata;
    e = o_pslverr;
    i_psel <= 1'b0; i_penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] v);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(nm, r, v);
  endtask : rchk
  task automatic pulse(input int k);
    @(posedge i_ref_clk) ev <= 10'h001 << k;
    @(posedge i_ref_clk) ev <= 10'h000;
  endtask : pulse
  task automatic ret();
    @(posedge i_ref_clk) i_return_from_irq <= 1'b1;
    @(posedge i_ref_clk) i_return_from_irq <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
  endtask : ret
  // cycles until vector (or wake) is seen, -1 if it never comes
  task automatic waitfor(input bit wk, input int lim, output int c);
    c = -1;
    for (int k = 1; k <= lim && c < 0; k++) begin
      @(posedge i_ref_clk);
      if ((wk ? o_wake : o_irq_vector) === 1'b1) c = k;
    end
  endtask : waitfor
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_ref_clk = 0; i_rstn = 0; i_psel = 0; i_penable = 0; i_pwrite = 0; i_paddr = 0;
    i_pwdata = 0; i_gpio = 0; ev = 0; i_sleep = 0; i_gie_clear_exec = 0;
    i_return_from_irq = 0; errors = 0; num_checks = 0; cycles = 0;
    repeat (20) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    repeat (6) @(posedge i_ref_clk);
    foreach (ra[i]) rchk("reset value", ra[i], 32'h0000_0000);
    apb(1'b0, 8'h20, 32'h0000_0000, x, pe);
    chk("unmapped", x, 32'h0000_0000);
    chk("unmapped error", pe, 1);
    wr(8'h04, 32'hFFFF_FFFF);
    rchk("pen_one", 8'h04, 32'h0000_0073);
    wr(8'h10, 32'hFFFF_FFFF);
    rchk("pen_two", 8'h10, 32'h0000_00B2);
    // every event flags with all interrupt_control enables clear
    pulse(0);
    rchk("timer0 flag", 8'h00, 32'h0000_0004);
    x = 0;
    for (int k = 1; k <= 9; k++) begin
      pulse(k);
      x |= 32'h0000_0001 << fb[k];
      rchk("peripheral flags", 8'h0C, x);
    end
    wr(8'h00, 32'h0000_0084);
    waitfor(0, 40, n);
    chk("group gated", n, -1);
    wr(8'h00, 32'h0000_00C4);
    waitfor(0, 40, n);
    chk("taken", 32'(n > 0), 1);
    chk("depth", depth, 1);
    rchk("enable cleared", 8'h00, 32'h0000_0044);
    pulse(0);
    rchk("flags kept", 8'h0C, 32'h0000_B273);
    ret();
    waitfor(0, 40, n);
    chk("retrigger", 32'(n > 0), 1);
    wr(8'h0C, 32'h0000_0000);
    ret();
    rchk("enable restored", 8'h00, 32'h0000_00C4);
    waitfor(0, 30, n);
    chk("masked timer0", n, -1);
    chk("stack empty", depth, 0);
    // timer0 path, software clears flag before return
    wr(8'h00, 32'h0000_00A0);
    pulse(0);
    waitfor(0, 30, n);
    chk("timer0 taken", 32'(n > 0), 1);
    wr(8'h00, 32'h0000_0020);
    ret();
    // enable-clearing instruction while a request arrives
    i_gie_clear_exec <= 1'b1;
    pulse(0);
    waitfor(0, 12, n);
    chk("clear blocks", n, -1);
    i_gie_clear_exec <= 1'b0;
    rchk("still pending", 8'h00, 32'h0000_0024);
    wr(8'h00, 32'h0000_00A4);
    waitfor(0, 30, n);
    chk("pending taken", 32'(n > 0), 1);
    chk("one service", depth, 1);
    wr(8'h00, 32'h0000_0020);
    ret();
    // external pin, rising edge selected
    wr(8'h08, 32'h0000_0001);
    wr(8'h00, 32'h0000_0090);
    i_gpio <= 8'h04;
    waitfor(0, 40, n);
    chk("pin latency", 32'(n >= 12 && n <= 20), 1);
    rchk("pin flag", 8'h00, 32'h0000_0012);
    wr(8'h00, 32'h0000_0010);
    ret();
    i_gpio <= 8'h00;
    repeat (12) @(posedge i_ref_clk);
    rchk("fall ignored", 8'h00, 32'h0000_0090);
    wr(8'h08, 32'h0000_0000);
    i_gpio <= 8'h04;
    repeat (12) @(posedge i_ref_clk);
    rchk("rise ignored", 8'h00, 32'h0000_0090);
    i_gpio <= 8'h00;
    waitfor(0, 40, n);
    chk("fall taken", 32'(n > 0), 1);
    wr(8'h00, 32'h0000_0010);
    ret();
    // sleep with pin enabled and global enable clear
    wr(8'h00, 32'h0000_0010);
    i_sleep <= 1'b1;
    i_gpio <= 8'h04;
    repeat (10) @(posedge i_ref_clk);
    i_gpio <= 8'h00;
    waitfor(1, 20, n);
    chk("wake", 32'(n > 0), 1);
    i_sleep <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    chk("wake drops", o_wake, 0);
    wr(8'h00, 32'h0000_0000);
    // analog pin reads zero and makes no edge
    wr(8'h08, 32'h0004_0000);
    i_gpio <= 8'h24;
    repeat (10) @(posedge i_ref_clk);
    chk("levels", o_pin_level, 8'h20);
    i_gpio <= 8'h20;
    repeat (10) @(posedge i_ref_clk);
    i_gpio <= 8'h24;
    rchk("analog quiet", 8'h00, 32'h0000_0000);
    // pin change only on selected pins
    wr(8'h08, 32'h0000_2000);
    wr(8'h00, 32'h0000_0008);
    i_gpio <= 8'h64;
    repeat (10) @(posedge i_ref_clk);
    rchk("unselected pin", 8'h00, 32'h0000_0008);
    i_gpio <= 8'h44;
    repeat (10) @(posedge i_ref_clk);
    rchk("selected pin", 8'h00, 32'h0000_0009);
    results();
  end
endmodule : test_mcu_interrupt_logic
